//--- inc/apdrc_defs.svh
// Purpose: constants for the converter phase-delay and reset control block
// Assumes: 20 MHz system clock
// Notes: offsets are register indices on the register port
`ifndef APDRC_DEFS_SVH
`define APDRC_DEFS_SVH
`define APDRC_ADDR_FIRST_CFG 2'h0
`define APDRC_ADDR_SECOND_CFG 2'h1
`define APDRC_ADDR_PHASE 2'h2
`define APDRC_ADDR_STATUS 2'h3
`define APDRC_TRIM_RESET 8'h50
`define APDRC_PHASE_RESET 12'h000
`define APDRC_EXTREF_BIT 0
`define APDRC_OSR_LSB 1
`define APDRC_PRE_LSB 4
`define APDRC_SECOND_RESET 8'h00
`define APDRC_CMP_RESET 4'h3
`define APDRC_SETTLE_US 1000
`define APDRC_CLK_MHZ 20
`define APDRC_SETTLE_CYC (`APDRC_SETTLE_US * `APDRC_CLK_MHZ)
`endif

//--- inc/apdrc_pkg.sv
// Purpose: types for the converter phase-delay and reset control block
// Assumes: nothing beyond the defs header
// Notes: register write carried as one struct
package apdrc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [11:0] data;
  } apdrc_req_t;
  typedef enum logic [1:0] {
    APDRC_HELD,
    APDRC_DELAY,
    APDRC_RUN
  } apdrc_state_t;
endpackage

//--- hw/apdrc_top.sv
// Purpose: reset, reference select and phase-delay control for one conversion channel
// Assumes: register requests arrive on clk_in; hard-reset pin is asynchronous
// Notes: data-ready and serial data outputs are three-state; data-ready is a value and enable pair, serial data an enable only
// Contract
// - select bit one routes reference pins as differential external input
// - select bit zero, the default, enables the internal reference
// - eight-bit trim field in first config bits 7:0, reset 0x50
// - after power-on, data-ready pulses run with default configuration
// - hard-reset low holds channel in reset, output code zero
// - hard reset clears modulator state; comparator reads 0011
// - hard reset clears filter and both output buffers
// - hard reset independent of serial port, registers to defaults
// - writes ignored while hard-reset pin low
// - serial data and data-ready go high impedance during hard reset
// - phase value is 12-bit two's complement, sign plus 11 bits
// - conversion delayed by phase plus half ratio modulator periods
// - delay resolution one modulator period; data-ready moves with it
// - effective delay spans zero to ratio minus one periods
// - any phase write resets and restarts the channel
// - value set for ratio 4096 stays valid at lower ratios
// - sign bit sits at bit 11 for 4096 down to bit 4 for 32
// - at 4096, 0x800 zero delay, 0x000 half, 0x7ff 4095
`timescale 1ns/10ps
`include "apdrc_defs.svh"

module apdrc_top
  import apdrc_pkg::*;
#(
  parameter int PHASE_W = 12,
  parameter int SETTLE_CYC = `APDRC_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // hard-reset pin, asynchronous to clk_in
  input wire logic hard_resetn_in,
  // register port
  input wire apdrc_req_t req_in,
  output logic [11:0] rdata_out,
  // modulator sample in and conversion results
  input wire logic [23:0] sample_in,
  output logic [23:0] code_out,
  output logic [3:0] comparator_out,
  // analog controls and settle flag
  output logic ext_reference_select_out,
  output logic int_reference_en_out,
  output logic [7:0] reference_tempco_trim_out,
  output logic settled_out,
  // data-ready pin (active low) and serial data pin, three-state
  output logic data_ready_pin_n_out,
  output logic data_ready_pin_oen_out,
  output logic sdo_oen_out
);

  ////////////////////////////////////////////////////////////////////////
  // hard-reset pin synchroniser; first stage feeds only the second
  logic hr_s1_r, hr_s2_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hr_s1_r <= 1'b0;
      hr_s2_r <= 1'b0;
    end else begin
      hr_s1_r <= hard_resetn_in;
      hr_s2_r <= hr_s1_r;
    end
  end
  // the two-flop lag means a write landing as the pin falls can still take effect;
  // the host is expected to stop writing before it pulls the pin low
  logic hard_rst;
  assign hard_rst = !hr_s2_r;

  // ratio code n: ratio = 32 << n, n in 0..7
  function automatic logic [12:0] ratio_of(input logic [2:0] n);
    ratio_of = 13'h0020 << n;
  endfunction

  // phase interpreted with sign at bit 4+n, returns total delay ratio/2+phase
  function automatic logic [11:0] delay_of(input logic [11:0] ph, input logic [2:0] n);
    logic [12:0] half;
    logic [12:0] mask;
    logic [12:0] sum;
    half = ratio_of(n) >> 1;
    mask = ratio_of(n) - 13'h0001;
    // flipping the sign bit adds half the ratio modulo the ratio
    sum = ({1'b0, ph} + half) & mask;
    delay_of = sum[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] trim_r, trim_nxt;
  logic [7:0] second_r, second_nxt;
  logic [11:0] phase_r, phase_nxt;
  logic restart_r, restart_nxt;
  always_comb begin
    trim_nxt = trim_r;
    second_nxt = second_r;
    phase_nxt = phase_r;
    restart_nxt = 1'b0;
    if (req_in.wr && !hard_rst) begin
      unique case (req_in.addr)
        `APDRC_ADDR_FIRST_CFG: trim_nxt = req_in.data[7:0];
        `APDRC_ADDR_SECOND_CFG: second_nxt = req_in.data[7:0];
        `APDRC_ADDR_PHASE: begin
          phase_nxt = req_in.data;
          restart_nxt = 1'b1;
        end
        `APDRC_ADDR_STATUS: ;
      endcase
    end
  end

  // hard reset wins over any write in the same cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trim_r <= `APDRC_TRIM_RESET;
      second_r <= `APDRC_SECOND_RESET;
      phase_r <= `APDRC_PHASE_RESET;
      restart_r <= 1'b0;
    end else if (hard_rst) begin
      trim_r <= `APDRC_TRIM_RESET;
      second_r <= `APDRC_SECOND_RESET;
      phase_r <= `APDRC_PHASE_RESET;
      restart_r <= 1'b0;
    end else begin
      trim_r <= trim_nxt;
      second_r <= second_nxt;
      phase_r <= phase_nxt;
      restart_r <= restart_nxt;
    end
  end

  // decoded fields of the second configuration register
  logic ext_sel;
  logic [2:0] osr_n;
  logic [2:0] pre_n;
  assign ext_sel = second_r[`APDRC_EXTREF_BIT];
  assign osr_n = second_r[`APDRC_OSR_LSB +: 3];
  assign pre_n = {1'b0, second_r[`APDRC_PRE_LSB +: 2]};
  assign ext_reference_select_out = ext_sel;
  assign int_reference_en_out = !ext_sel;
  assign reference_tempco_trim_out = trim_r;

  ////////////////////////////////////////////////////////////////////////
  // modulator clock enable: clk_in divided by 2 << prescale
  logic [3:0] div_r, div_nxt;
  logic mod_tick;
  always_comb begin
    mod_tick = (div_r == 4'h0);
    div_nxt = mod_tick ? 4'((4'h2 << pre_n) - 4'h1) : div_r - 4'h1;
  end

  // divider runs free so restarts stay aligned to the tick grid
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) div_r <= 4'h0;
    else div_r <= div_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // phase delay then conversion sequencer
  apdrc_state_t st_r, st_nxt;
  logic [12:0] cnt_r, cnt_nxt;
  logic [23:0] acc_r, acc_nxt;
  logic [23:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt;
  logic dr_r, dr_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    buf_a_nxt = buf_a_r;
    buf_b_nxt = buf_b_r;
    dr_nxt = 1'b0;
    if (restart_r) begin
      st_nxt = APDRC_DELAY;
      cnt_nxt = {1'b0, delay_of(phase_r, osr_n)};
      acc_nxt = 24'h000000;
    end else if (mod_tick) begin
      unique case (st_r)
        APDRC_HELD: begin
          st_nxt = APDRC_DELAY;
          cnt_nxt = {1'b0, delay_of(phase_r, osr_n)};
        end
        APDRC_DELAY: begin
          if (cnt_r == 13'h0000) begin
            st_nxt = APDRC_RUN;
            cnt_nxt = ratio_of(osr_n) - 13'h0001;
          end else begin
            cnt_nxt = cnt_r - 13'h0001;
          end
        end
        APDRC_RUN: begin
          acc_nxt = acc_r + sample_in;
          if (cnt_r == 13'h0000) begin
            buf_b_nxt = buf_a_r;
            buf_a_nxt = acc_r + sample_in;
            acc_nxt = 24'h000000;
            dr_nxt = 1'b1;
            cnt_nxt = ratio_of(osr_n) - 13'h0001;
          end else begin
            cnt_nxt = cnt_r - 13'h0001;
          end
        end
      endcase
    end
  end

  // sequencer state; hard reset clears modulator, filter and buffers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= APDRC_HELD;
      cnt_r <= 13'h0000;
      acc_r <= 24'h000000;
      buf_a_r <= 24'h000000;
      buf_b_r <= 24'h000000;
      dr_r <= 1'b0;
    end else if (hard_rst) begin
      st_r <= APDRC_HELD;
      cnt_r <= 13'h0000;
      acc_r <= 24'h000000;
      buf_a_r <= 24'h000000;
      buf_b_r <= 24'h000000;
      dr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      buf_a_r <= buf_a_nxt;
      buf_b_r <= buf_b_nxt;
      dr_r <= dr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settling timer after any reset, for the host's benefit
  // a fixed count only: it does not track the filter settling per ratio
  logic [31:0] settle_r, settle_nxt;
  always_comb begin
    settle_nxt = (restart_r || hard_rst) ? 32'(SETTLE_CYC) :
                 (settle_r != 32'h0) ? settle_r - 32'h1 : settle_r;
  end

  // power-on starts the timer full, like any other reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) settle_r <= 32'(SETTLE_CYC);
    else settle_r <= settle_nxt;
  end
  assign settled_out = (settle_r == 32'h0);

  ////////////////////////////////////////////////////////////////////////
  // outputs; code comes from a flop cleared by hard reset, comparator is sample_in bits 3:0 in run or the idle code
  assign code_out = buf_a_r;
  assign comparator_out = (st_r == APDRC_RUN) ? sample_in[3:0] : `APDRC_CMP_RESET;
  assign data_ready_pin_n_out = !dr_r;
  assign data_ready_pin_oen_out = hard_rst;
  assign sdo_oen_out = hard_rst;

  // register readback; status shows sequencer state and settle flag
  always_comb begin
    rdata_out = 12'h000;
    unique case (req_in.addr)
      `APDRC_ADDR_FIRST_CFG: rdata_out = {4'h0, trim_r};
      `APDRC_ADDR_SECOND_CFG: rdata_out = {4'h0, second_r};
      `APDRC_ADDR_PHASE: rdata_out = phase_r;
      `APDRC_ADDR_STATUS: rdata_out = {9'h000, settled_out, st_r};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // hard-reset effects on registers, pins and outputs
  a_write_blocked: assert property (@(posedge clk_in) disable iff (!resetn_in)
    hard_rst |=> $stable(phase_r) || phase_r == `APDRC_PHASE_RESET)
    else $error("write during hard reset");
  a_trim_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
    hard_rst |=> trim_r == 8'h50)
    else $error("trim not default");
  a_hiz_pins: assert property (@(posedge clk_in) disable iff (!resetn_in)
    hard_rst |-> data_ready_pin_oen_out && sdo_oen_out)
    else $error("pins driven in reset");
  a_code_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    hard_rst |=> code_out == 24'h0 && comparator_out == 4'h3)
    else $error("code not cleared");

  // phase restart and delay range
  a_phase_restart: assert property (@(posedge clk_in) disable iff (!resetn_in || hard_rst)
    restart_r |=> st_r == APDRC_DELAY && cnt_r == {1'b0, delay_of($past(phase_r), osr_n)})
    else $error("no restart");
  a_delay_range: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_r == APDRC_DELAY |-> cnt_r < ratio_of(osr_n))
    else $error("delay out of range");

  // reference select and data ready
  a_ref_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
    int_reference_en_out != ext_reference_select_out)
    else $error("reference select");
  a_dr_only_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
    dr_r |-> $past(st_r) == APDRC_RUN)
    else $error("data ready early");

  // data ready is a single-cycle pulse
  a_dr_single: assert property (@(posedge clk_in) disable iff (!resetn_in)
    dr_r |=> !dr_r)
    else $error("data ready too long");
  // comparator shows the idle code whenever not converting
  a_cmp_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_r != APDRC_RUN |-> comparator_out == `APDRC_CMP_RESET)
    else $error("comparator not idle");
  // accumulator and second buffer empty after hard reset
  a_buffers_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    hard_rst |=> acc_r == 24'h000000 && buf_b_r == 24'h000000)
    else $error("filter not cleared");
  // second configuration back to default under hard reset
  a_cfg_default: assert property (@(posedge clk_in) disable iff (!resetn_in)
    hard_rst |=> second_r == `APDRC_SECOND_RESET)
    else $error("config not default");
  // a restart reopens the settling window
  a_restart_unsettled: assert property (@(posedge clk_in) disable iff (!resetn_in)
    restart_r |=> !settled_out)
    else $error("settled after restart");
  // modulator ticks never fall in adjacent cycles
  a_tick_gap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    mod_tick |=> !mod_tick)
    else $error("tick too fast");
  // delay ending at zero hands over to conversion
  a_delay_to_run: assert property (@(posedge clk_in) disable iff (!resetn_in || hard_rst)
    st_r == APDRC_DELAY && mod_tick && cnt_r == 13'h0000 && !restart_r |=> st_r == APDRC_RUN)
    else $error("delay did not end");
  // external select pin follows its configuration bit
  a_ext_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ext_reference_select_out == second_r[`APDRC_EXTREF_BIT])
    else $error("external select wrong");
  // data ready only at the end of a full conversion count
  a_dr_from_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
    dr_r |-> $past(cnt_r) == 13'h0000)
    else $error("data ready mid count");

  // main scenarios
  c_restart: cover property (@(posedge clk_in) restart_r);
  c_dr: cover property (@(posedge clk_in) dr_r);
  c_hard: cover property (@(posedge clk_in) hard_rst ##1 !hard_rst);
  c_ext_ref: cover property (@(posedge clk_in) ext_sel);
  c_long_ratio: cover property (@(posedge clk_in) dr_r && osr_n != 3'h0);

endmodule // apdrc_top

//--- sim/apdrc_host_model.sv
// Purpose: host model feeding modulator samples and collecting conversions
// Assumes: data-ready pin has a pull-up while released
// Notes: pulses before settling are dropped, as a real host must
`timescale 1ns/10ps
module apdrc_host_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // pins from the block
  input wire logic data_ready_pin_n_in,
  input wire logic data_ready_pin_oen_in,
  input wire logic settled_in,
  input wire logic [23:0] code_in,
  // towards the block and the bench
  output logic [23:0] sample_out,
  output logic [15:0] taken_count_out,
  output logic [23:0] last_code_out
);
  logic dr_wire;
  ////////////////////////////////////////
  // released pin floats up, so no stale pulse
  assign dr_wire = data_ready_pin_oen_in ? 1'b1 : data_ready_pin_n_in;
  // odd constant so a sum differs from the idle comparator code
  assign sample_out = 24'h000005;
  // early pulses carry unsettled data and are thrown away
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      taken_count_out <= 16'h0000;
      last_code_out <= 24'h000000;
    end else if (!dr_wire && settled_in) begin
      taken_count_out <= taken_count_out + 16'h0001;
      last_code_out <= code_in;
    end
  end
endmodule // apdrc_host_model

//--- sim/tb_top.sv
// Purpose: self-checking bench for the phase-delay and reset control block
// Assumes: 20 MHz clock, settle count shortened to 50
// Notes: delays are checked as differences against a zero-delay write
`timescale 1ns/10ps
`include "apdrc_defs.svh"
module tb_top;
  import apdrc_pkg::*;
  logic clk_in, resetn_in, hard_resetn_in, ext_sel, int_en, settled, dr_n, dr_oen, sdo_oen;
  apdrc_req_t req_in;
  logic [11:0] rdata;
  logic [23:0] sample, code, last_code;
  logic [3:0] cmp;
  logic [7:0] trim;
  logic [15:0] taken;
  int fail_count, checked, ref_lat, lat, ratio, tick;
  logic [7:0] cfgs [2] = '{8'h00, 8'h12};
  logic [11:0] phases [4] = '{12'h000, 12'h00f, 12'h7ff, 12'hfff};
  ////////////////////////////////////////
  apdrc_top #(.SETTLE_CYC(50)) apdrc_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .hard_resetn_in(hard_resetn_in), .req_in(req_in), .rdata_out(rdata), .sample_in(sample),
    .code_out(code), .comparator_out(cmp), .ext_reference_select_out(ext_sel),
    .int_reference_en_out(int_en), .reference_tempco_trim_out(trim), .settled_out(settled),
    .data_ready_pin_n_out(dr_n), .data_ready_pin_oen_out(dr_oen), .sdo_oen_out(sdo_oen));
  apdrc_host_model apdrc_host_model_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .data_ready_pin_n_in(dr_n), .data_ready_pin_oen_in(dr_oen), .settled_in(settled),
    .code_in(code), .sample_out(sample), .taken_count_out(taken), .last_code_out(last_code));
  // free-running 50 ns clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [11:0] d);
    @(posedge clk_in);
    req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clk_in);
    req_in.wr <= 1'b0;
  endtask
  // readback is combinational, so look just after the address lands
  task automatic rd(input logic [1:0] a, input logic [11:0] exp, input string what);
    @(posedge clk_in);
    req_in.addr <= a;
    #1 check(what, {12'h000, rdata}, {12'h000, exp});
  endtask
  // bounded wait so a lost pulse shows as a wrong latency, not a hang
  task automatic run_phase(input logic [11:0] p, output int n);
    wr(`APDRC_ADDR_PHASE, p);
    n = 0;
    while (dr_n !== 1'b0 && n < 5000) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_in);
    fail_count++;
    wrap_up();
  end
  initial begin
    resetn_in = 1'b0;
    hard_resetn_in = 1'b1;
    req_in = '0;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(`APDRC_ADDR_FIRST_CFG, 12'h050, "trim reset");
    rd(`APDRC_ADDR_SECOND_CFG, 12'h000, "second cfg reset");
    rd(`APDRC_ADDR_PHASE, 12'h000, "phase reset");
    check("ref enables", {ext_sel, int_en}, 2'b01);
    check("trim out", trim, 8'h50);
    repeat (300) @(posedge clk_in);
    check("pulses after power-on", taken != 16'h0000, 1'b1);
    check("conversion sum", last_code, 24'h0000a0);
    wr(`APDRC_ADDR_SECOND_CFG, 12'h001);
    #1 check("ext ref", {ext_sel, int_en}, 2'b10);
    wr(`APDRC_ADDR_SECOND_CFG, 12'h000);
    #1 check("int ref", {ext_sel, int_en}, 2'b01);
    wr(`APDRC_ADDR_FIRST_CFG, 12'h042);
    wr(`APDRC_ADDR_STATUS, 12'hfff);
    rd(`APDRC_ADDR_FIRST_CFG, 12'h042, "trim write");
    // ratio 32 at prescale 0, then ratio 64 at prescale 1: zero-delay write three times, then the table
    foreach (cfgs[c]) begin
      ratio = 32 << cfgs[c][3:1];
      tick = 2 << cfgs[c][5:4];
      wr(`APDRC_ADDR_SECOND_CFG, {4'h0, cfgs[c]});
      // first run only lines the restart up with the modulator tick
      run_phase(12'(ratio / 2), ref_lat);
      run_phase(12'(ratio / 2), ref_lat);
      run_phase(12'(ratio / 2), lat);
      check("same phase restart", 24'(lat), 24'(ref_lat));
      foreach (phases[i]) begin
        run_phase(phases[i], lat);
        check("phase delay", 24'(lat - ref_lat), 24'(tick * (((phases[i] & (ratio - 1)) + ratio / 2) % ratio)));
      end
    end
    wr(`APDRC_ADDR_PHASE, 12'h000);
    repeat (5) @(posedge clk_in);
    #1 check("settle start", settled, 1'b0);
    repeat (60) @(posedge clk_in);
    #1 check("settle end", settled, 1'b1);
    // hard reset in mid-run, with a write attempted under it
    @(posedge clk_in);
    hard_resetn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr(`APDRC_ADDR_PHASE, 12'h123);
    #1 check("pins released", {dr_oen, sdo_oen}, 2'b11);
    check("code held", code, 24'h000000);
    check("comparator", cmp, 4'h3);
    rd(`APDRC_ADDR_FIRST_CFG, 12'h050, "trim default");
    rd(`APDRC_ADDR_PHASE, 12'h000, "write ignored");
    @(posedge clk_in);
    hard_resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1 check("pins driven", {dr_oen, sdo_oen}, 2'b00);
    rd(`APDRC_ADDR_SECOND_CFG, 12'h000, "cfg default");
    wrap_up();
  end
endmodule // tb_top
